// >>> logic/tpa_defs.vh
`ifndef TPA_DEFS_VH
`define TPA_DEFS_VH

// ==========================================================================
// Register map, per channel. Address = {channel[2:0], offset[4:0]}.
// ==========================================================================
`define TPA_OFF_SEG4      5'h0b
`define TPA_OFF_SEG5      5'h0c
`define TPA_RESET_SEG     8'h00
`define TPA_AMP_SIGN_BIT  6
`define TPA_AMP_MSB       6
`define TPA_NUM_SEGMENTS  8
`define TPA_SEG4_INDEX    3'h3
`define TPA_SEG5_INDEX    3'h4

`endif

// >>> logic/tpa_seg_timer.v
`timescale 1ns/1ps
`include "tpa_defs.vh"

// ==========================================================================
// Segment sequencer. One pulse is one master-clock period; the fast clock
// runs eight times faster, so each of its cycles is one segment.
// ==========================================================================
module tpa_seg_timer
(
   // Clock and reset
   input  wire       i_clock,
   input  wire       i_rstn,
   // Pulse control
   input  wire       i_pulse_start,
   output reg  [2:0] o_segment,
   output reg        o_active
);

   reg [2:0] seg_next;
   reg       act_next;

   always @*
   begin
      seg_next = o_segment;
      act_next = o_active;
      if (o_active)
      begin
         // Segments advance in order, one per clock.
         seg_next = o_segment + 3'h1;
         if (o_segment == 3'h7)
         begin
            act_next = i_pulse_start;
         end
      end
      else if (i_pulse_start)
      begin
         seg_next = 3'h0;
         act_next = 1'b1;
      end
   end

   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_segment <= 3'h0;
         o_active  <= 1'b0;
      end
      else
      begin
         o_segment <= seg_next;
         o_active  <= act_next;
      end
   end

endmodule

// >>> logic/tpa_regs.v
`timescale 1ns/1ps
`include "tpa_defs.vh"

module tpa_regs
#(
   parameter NUM_CH = 8
)
(
   // Clock and reset; i_clock is eight times the master-clock rate
   input  wire                i_clock,
   input  wire                i_rstn,
   // Host register port
   input  wire [7:0]          i_addr,
   input  wire                i_wr,
   input  wire                i_rd,
   input  wire [7:0]          i_wdata,
   output reg  [7:0]          o_rdata,
   // Pulse control, one start per channel
   input  wire [NUM_CH-1:0]   i_pulse_start,
   // Per-channel amplitude, packed 7 bits per channel
   output reg  [NUM_CH*7-1:0] o_amplitude,
   output reg  [NUM_CH-1:0]   o_amp_valid,
   output reg  [NUM_CH-1:0]   o_seg4_active,
   output reg  [NUM_CH-1:0]   o_seg5_active
);

   // ========================================================================
   // Registers
   // ========================================================================
   reg  [7:0] seg4_reg [0:NUM_CH-1];
   reg  [7:0] seg5_reg [0:NUM_CH-1];
   wire [2:0] ch_sel = i_addr[7:5];
   wire [4:0] off    = i_addr[4:0];
   wire [2:0] seg_w  [0:NUM_CH-1];
   wire       act_w  [0:NUM_CH-1];
   integer    k;

   // Magnitude of zero with either sign gives zero drive; negative zero is folded.
   function [6:0] tpa_sm_clean;
      input [6:0] v;
      begin
         if (v[5:0] == 6'h00)
            tpa_sm_clean = 7'h00;
         else
            tpa_sm_clean = v;
      end
   endfunction

   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         for (k = 0; k < NUM_CH; k = k + 1)
         begin
            seg4_reg[k] <= `TPA_RESET_SEG;
            seg5_reg[k] <= `TPA_RESET_SEG;
         end
      end
      else if (i_wr && (ch_sel < NUM_CH))
      begin
         // Each channel decodes its own bank.
         if (off == `TPA_OFF_SEG4)
            seg4_reg[ch_sel] <= i_wdata;
         if (off == `TPA_OFF_SEG5)
            seg5_reg[ch_sel] <= i_wdata;
      end
   end

   // ========================================================================
   // Read back; reserved bit 7 is stored and returned as written
   // ========================================================================
   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rdata <= 8'h00;
      else if (i_rd && (ch_sel < NUM_CH) && (off == `TPA_OFF_SEG4))
         o_rdata <= seg4_reg[ch_sel];
      else if (i_rd && (ch_sel < NUM_CH) && (off == `TPA_OFF_SEG5))
         o_rdata <= seg5_reg[ch_sel];
      else if (i_rd)
         o_rdata <= 8'h00;
   end

   // ========================================================================
   // Per-channel pulse sequencing
   // ========================================================================
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1)
      begin : ch
         tpa_seg_timer u_timer
         (
            .i_clock       (i_clock),
            .i_rstn        (i_rstn),
            .i_pulse_start (i_pulse_start[g]),
            .o_segment     (seg_w[g]),
            .o_active      (act_w[g])
         );

         // Registered so the level only moves on a segment edge.
         always @(posedge i_clock or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               o_amplitude[g*7 +: 7] <= 7'h00;
               o_amp_valid[g]        <= 1'b0;
               o_seg4_active[g]      <= 1'b0;
               o_seg5_active[g]      <= 1'b0;
            end
            else
            begin
               o_amp_valid[g]   <= act_w[g];
               o_seg4_active[g] <= act_w[g] && (seg_w[g] == `TPA_SEG4_INDEX);
               o_seg5_active[g] <= act_w[g] && (seg_w[g] == `TPA_SEG5_INDEX);
               if (act_w[g] && (seg_w[g] == `TPA_SEG4_INDEX))
                  o_amplitude[g*7 +: 7] <= tpa_sm_clean(seg4_reg[g][6:0]);
               else if (act_w[g] && (seg_w[g] == `TPA_SEG5_INDEX))
                  o_amplitude[g*7 +: 7] <= tpa_sm_clean(seg5_reg[g][6:0]);
               else
                  o_amplitude[g*7 +: 7] <= 7'h00;
            end
         end
      end
   endgenerate

endmodule

// >>> test/tpa_regs_asserts.sv
`timescale 1ns/1ps
// ====
// Channel 0 only; the bench reads back every channel's registers but pulses channel 0 only.
module tpa_chk #(parameter NUM_CH = 8)
(
   input wire                i_clock,
   input wire                i_rstn,
   input wire [7:0]          i_addr,
   input wire                i_wr,
   input wire [7:0]          i_wdata,
   input wire [NUM_CH*7-1:0] o_amplitude,
   input wire [NUM_CH-1:0]   o_amp_valid,
   input wire [NUM_CH-1:0]   o_seg4_active,
   input wire [NUM_CH-1:0]   o_seg5_active
);
   reg  [6:0] s4_reg;
   wire [6:0] a0 = o_amplitude[6:0];
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   always @(posedge i_clock or negedge i_rstn)
      if (!i_rstn)
         s4_reg <= 7'h0;
      else if (i_wr && i_addr == 8'h0b)
         s4_reg <= i_wdata[6:0];
   chk_span_eight: assert property ($rose(o_amp_valid[0]) |-> o_amp_valid[0] [*8])
      else $error("pulse short");
   chk_seg4_place: assert property ($rose(o_amp_valid[0]) |-> ##3 o_seg4_active[0])
      else $error("seg4 late");
   chk_seg4_value: assert property (o_seg4_active[0] && s4_reg != 7'h40 |-> a0 == s4_reg)
      else $error("seg4 value");
   chk_seg5_next: assert property (o_seg4_active[0] |=> o_seg5_active[0])
      else $error("seg5 missing");
   chk_seg5_once: assert property (o_seg5_active[0] |=> !o_seg5_active[0])
      else $error("seg5 long");
   chk_idle_quiet: assert property (!o_amp_valid[0] |-> a0 == 7'h0 && !o_seg4_active[0])
      else $error("idle output");
   cover property ($rose(o_amp_valid[0]));
   cover property (o_seg5_active[0] && a0 != 7'h0);
   cover property (i_wr && i_addr == 8'h0c);
endmodule
bind tpa_regs tpa_chk #(.NUM_CH(NUM_CH)) u_chk (.i_clock(i_clock), .i_rstn(i_rstn),
   .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .o_amplitude(o_amplitude),
   .o_amp_valid(o_amp_valid), .o_seg4_active(o_seg4_active), .o_seg5_active(o_seg5_active));

// >>> test/tpa_host.sv
`timescale 1ns/1ps
// ====
// Host model. Read data is taken a cycle late, as it holds until the next read.
module tpa_host
(
   input  wire       i_clock,
   input  wire [7:0] i_rdata,
   output reg  [7:0] o_addr = 8'h0,
   output reg        o_wr = 1'b0,
   output reg        o_rd = 1'b0,
   output reg  [7:0] o_wdata = 8'h0
);
   task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
      begin
         @(negedge i_clock);
         {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
         @(negedge i_clock);
         {o_wr, o_rd} = 2'b00;
         @(negedge i_clock);
         q = i_rdata;
      end
   endtask
endmodule

// >>> test/tpa_regs_test.sv
`timescale 1ns/1ps
// ====
// Register map and pulse tests.
module tpa_regs_test;
   reg         i_clock = 1'b0;
   reg         i_rstn = 1'b0;
   reg  [7:0]  start = 8'h0;
   reg  [7:0]  q;
   wire [7:0]  addr, wdata, rdata, valid, s4, s5;
   wire        wr, rd;
   wire [55:0] amp;
   integer     failures = 0, total_checks = 0, c;
   always #5 i_clock = ~i_clock;
   tpa_host host (.i_clock(i_clock), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata));
   tpa_regs dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(addr), .i_wr(wr), .i_rd(rd),
      .i_wdata(wdata), .o_rdata(rdata), .i_pulse_start(start), .o_amplitude(amp),
      .o_amp_valid(valid), .o_seg4_active(s4), .o_seg5_active(s5));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
            failures = failures + 1;
         if (got !== exp)
            $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      repeat (12) @(posedge i_clock);
      @(negedge i_clock) i_rstn = 1'b1;
      for (c = 0; c < 16; c = c + 1)
      begin
         host.xfer(1'b0, 8'(c / 2 * 32 + 11 + c % 2), 8'h0, q);
         chk(q, 8'h00);
         host.xfer(1'b1, 8'(c / 2 * 32 + 11 + c % 2), 8'(8'h81 + c), q);
         host.xfer(1'b0, 8'(c / 2 * 32 + 11 + c % 2), 8'h0, q);
         chk(q, 8'(8'h81 + c));
      end
      $display("regs done");
      host.xfer(1'b1, 8'h0b, 8'hc5, q);
      @(negedge i_clock) start = 8'h01;
      @(negedge i_clock) start = 8'h00;
      for (c = 0; c < 20 && s4[0] !== 1'b1; c = c + 1)
         @(negedge i_clock);
      chk({s4[0], amp[6:0]}, 8'hc5);
      if (c == 20)
         close_out;
      chk({1'b0, amp[13:7]}, 8'h00);
      @(negedge i_clock);
      chk({s5[0], amp[6:0]}, 8'h82);
      repeat (4) @(negedge i_clock);
      chk(valid, 8'h00);
      $display("pulse done");
      close_out;
   end
endmodule
